// *** common/hmp_pkg.sv ***
// Function
// - memory pointer sets start of accesses
// - pointer loaded, then advances per access
// - memory data window, reads zero initially
// - edge pulses spaced by microframe gap
// - gap ignored in level mode
// - zero gap fires on an event once no pulse runs
// - edge pulse lasts programmed clock cycles
// - pulse width resets to fifteen
// - separate dma data window into memory
// - write-only dma pointer, resets zero
// - power-down control register with fields
// - stay awake for clock-off interval
package hmp_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    // register index; byte address is four times it
    localparam logic [IDX_W-1:0] IDX_DMA_DATA = 10'h060;
    localparam logic [IDX_W-1:0] IDX_MEM_PTR = 10'h0C4;
    localparam logic [IDX_W-1:0] IDX_MEM_DATA = 10'h0C6;
    localparam logic [IDX_W-1:0] IDX_IRQ_SHAPE = 10'h0C8;
    localparam logic [IDX_W-1:0] IDX_DMA_PTR = 10'h0CC;
    localparam logic [IDX_W-1:0] IDX_PWR = 10'h0D0;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h0E0;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 10'h0E1;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 10'h0E2;
    localparam logic [IDX_W-1:0] IDX_IRQ_MODE = 10'h0E3;
    localparam logic [IDX_W-1:0] IDX_PWR_STATE = 10'h0E4;

    localparam int IRQ_N = 2;
    localparam int IRQ_HOST = 0;
    localparam int IRQ_WAKE = 1;

    localparam int CLK_PERIOD_NS = 10;
    localparam int UFRAME_NS = 125000;
    localparam int UFRAME_CYCLES_DEF = UFRAME_NS / CLK_PERIOD_NS;
    localparam int WAKE_TICK_CYCLES_DEF = 100;
    localparam int TICK_W = 16;

    typedef struct packed {
        logic [7:0] min_gap;
        logic [7:0] rsv;
        logic [15:0] irq_pulse_cycles;
    } hmp_shape_t;

    typedef struct packed {
        logic [15:0] clk_off_count;
        logic port2_force_fs;
        logic port1_force_fs;
        logic [1:0] rsv13_12;
        logic port2_pulldown;
        logic rsv10;
        logic port2_oc_en;
        logic port1_oc_en;
        logic transceiver2_power_on;
        logic rsv6;
        logic regulator_power;
        logic regulator_suspend_power;
        logic rsv3;
        logic port2_otg_en;
        logic port1_otg_en;
        logic host_clock_gate;
    } hmp_pwr_t;

    localparam logic [15:0] RST_PTR = 16'h0000;
    localparam logic [31:0] RST_SHAPE = 32'h0000000F;
    localparam logic [31:0] RST_PWR = 32'h03E81BA0;

    typedef enum logic [1:0] {
        PS_SUSPEND = 2'b00,
        PS_HOLD = 2'b01,
        PS_RUN = 2'b10
    } hmp_pstate_t;
endpackage

// *** dv/hmp_apb_host.sv ***
`timescale 1ns/1ps
module hmp_apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [hmp_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // one apb transfer; held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [hmp_pkg::IDX_W-1:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines flip so stale values are never mistaken for live ones
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask
endmodule // hmp_apb_host

// *** dv/hmp_regs_tb_top.sv ***
`timescale 1ns/1ps
module hmp_regs_tb_top;
    typedef struct packed {
        logic wr;
        logic [hmp_pkg::IDX_W-1:0] idx;
        logic [31:0] wd;
        logic [31:0] exp;
        logic err;
    } hmp_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic host_event = 1'b0;
    logic wake_pin = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, int_out, suspended, err, int_prev;
    logic [hmp_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    hmp_pkg::hmp_pwr_t power_ctrl;
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    int hi_cnt = 0;
    int rises[$];
    hmp_row_t rows [23] = '{
        '{1'b0, hmp_pkg::IDX_IRQ_SHAPE, 32'h0, 32'h0000000F, 1'b0},
        '{1'b0, hmp_pkg::IDX_PWR, 32'h0, 32'h03E81BA0, 1'b0},
        '{1'b0, hmp_pkg::IDX_MEM_PTR, 32'h0, 32'h0, 1'b0},
        '{1'b0, hmp_pkg::IDX_MEM_DATA, 32'h0, 32'h0, 1'b0},
        '{1'b0, hmp_pkg::IDX_DMA_PTR, 32'h0, 32'h0, 1'b0},
        '{1'b0, 10'h3FF, 32'h0, 32'h0, 1'b1},
        '{1'b1, 10'h3FF, 32'h12345678, 32'h0, 1'b1},
        '{1'b1, hmp_pkg::IDX_MEM_PTR, 32'hFFFF0010, 32'h0, 1'b0},
        '{1'b0, hmp_pkg::IDX_MEM_PTR, 32'h0, 32'h00000010, 1'b0},
        '{1'b1, hmp_pkg::IDX_MEM_DATA, 32'h00001111, 32'h0, 1'b0},
        '{1'b1, hmp_pkg::IDX_MEM_DATA, 32'h00002222, 32'h0, 1'b0},
        '{1'b0, hmp_pkg::IDX_MEM_PTR, 32'h0, 32'h00000012, 1'b0},
        '{1'b1, hmp_pkg::IDX_DMA_PTR, 32'h00000011, 32'h0, 1'b0},
        '{1'b0, hmp_pkg::IDX_DMA_PTR, 32'h0, 32'h0, 1'b0},
        '{1'b0, hmp_pkg::IDX_DMA_DATA, 32'h0, 32'h00002222, 1'b0},
        '{1'b0, hmp_pkg::IDX_DMA_DATA, 32'h0, 32'h0, 1'b0},
        '{1'b1, hmp_pkg::IDX_DMA_DATA, 32'h00003333, 32'h0, 1'b0},
        '{1'b1, hmp_pkg::IDX_MEM_PTR, 32'h00000010, 32'h0, 1'b0},
        '{1'b0, hmp_pkg::IDX_MEM_DATA, 32'h0, 32'h00001111, 1'b0},
        '{1'b0, hmp_pkg::IDX_MEM_DATA, 32'h0, 32'h00002222, 1'b0},
        '{1'b0, hmp_pkg::IDX_MEM_DATA, 32'h0, 32'h0, 1'b0},
        '{1'b0, hmp_pkg::IDX_MEM_DATA, 32'h0, 32'h00003333, 1'b0},
        '{1'b1, hmp_pkg::IDX_PWR, 32'h00081BA1, 32'h0, 1'b0}
    };

    always #5 pclk = ~pclk;

    hmp_apb_host hmp_apb_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    hmp_regs #(.UFRAME_CYCLES(20), .WAKE_TICK_CYCLES(4)) hmp_regs_i (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_event(host_event),
        .wake_pin(wake_pin), .irq(irq), .int_out(int_out), .suspended(suspended),
        .power_ctrl(power_ctrl));

    // pulse monitor, sampled mid-cycle where outputs are settled
    always @(negedge pclk) begin
        cyc++;
        if (int_out === 1'b1) hi_cnt++;
        if (int_out === 1'b1 && int_prev !== 1'b1) rises.push_back(cyc);
        int_prev = int_out;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [hmp_pkg::IDX_W-1:0] idx, input logic [31:0] wd);
        hmp_apb_host_i.xfer(1'b1, idx, wd, rd, err);
    endtask
    task automatic rdc(input string what, input logic [hmp_pkg::IDX_W-1:0] idx, input logic [31:0] exp);
        hmp_apb_host_i.xfer(1'b0, idx, 32'h0, rd, err);
        check(what, exp, rd);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic fire();
        @(posedge pclk);
        host_event <= 1'b1;
        @(posedge pclk);
        host_event <= 1'b0;
    endtask
    task automatic mon_clear();
        @(negedge pclk);
        rises.delete();
        hi_cnt = 0;
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        idle(20000);
        bad_count++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        idle(12);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            hmp_apb_host_i.xfer(rows[i].wr, rows[i].idx, rows[i].wd, rd, err);
            if (!rows[i].wr) check("read data", rows[i].exp, rd);
            check("slave error", {31'h0, rows[i].err}, {31'h0, err});
        end
        // the last write commits at this very edge; look once it has settled
        @(negedge pclk);
        check("power outputs", 32'h00081BA1, power_ctrl);
        $display("register table done");
        wr(hmp_pkg::IDX_IRQ_ENABLE, 32'h1);
        wr(hmp_pkg::IDX_IRQ_MODE, 32'h1);
        wr(hmp_pkg::IDX_IRQ_SHAPE, 32'h00000005);
        mon_clear();
        fire();
        idle(10);
        fire();
        idle(12);
        check("pulse count", 32'h2, rises.size());
        check("pulse spacing", 32'hC, rises[1] - rises[0]);
        check("pulse high cycles", 32'hA, hi_cnt);
        check("irq level", 32'h1, {31'h0, irq});
        $display("edge pulse test done");
        wr(hmp_pkg::IDX_IRQ_SHAPE, 32'h02000005);
        mon_clear();
        fire();
        idle(3);
        fire();
        idle(60);
        check("gapped pulse count", 32'h2, rises.size());
        check("gap in range", 32'h1, {31'h0, rises[1] - rises[0] >= 19 && rises[1] - rises[0] <= 42});
        check("gapped high cycles", 32'hA, hi_cnt);
        $display("gap test done");
        wr(hmp_pkg::IDX_IRQ_MODE, 32'h0);
        idle(2);
        check("level follows irq", 32'h1, {31'h0, int_out});
        wr(hmp_pkg::IDX_IRQ_CLEAR, 32'h1);
        idle(2);
        check("cleared int", 32'h0, {30'h0, irq, int_out});
        fire();
        idle(30);
        check("level held past gap", 32'h1, {31'h0, int_out});
        wr(hmp_pkg::IDX_IRQ_ENABLE, 32'h0);
        idle(2);
        check("masked irq", 32'h0, {30'h0, irq, int_out});
        rdc("sticky status", hmp_pkg::IDX_IRQ_STATUS, 32'h1);
        wr(hmp_pkg::IDX_IRQ_CLEAR, 32'h3);
        rdc("status cleared", hmp_pkg::IDX_IRQ_STATUS, 32'h0);
        $display("level and mask test done");
        // clock gate low sends the block to suspend; counter 8 ticks of 4 cycles
        wr(hmp_pkg::IDX_PWR, 32'h00081BA0);
        idle(2);
        check("suspended", 32'h1, {31'h0, suspended});
        @(posedge pclk);
        wake_pin <= 1'b1;
        idle(8);
        check("awake after wake", 32'h0, {31'h0, suspended});
        rdc("hold state", hmp_pkg::IDX_PWR_STATE, 32'h1);
        rdc("wake status", hmp_pkg::IDX_IRQ_STATUS, 32'h2);
        idle(40);
        check("back to suspend", 32'h1, {31'h0, suspended});
        // wake again, then reprogram inside the interval to cancel the fall-back
        wake_pin <= 1'b0;
        idle(6);
        wake_pin <= 1'b1;
        idle(8);
        rdc("woken again", hmp_pkg::IDX_PWR_STATE, 32'h1);
        wr(hmp_pkg::IDX_PWR, 32'h00081BA1);
        rdc("run state", hmp_pkg::IDX_PWR_STATE, 32'h2);
        check("running", 32'h0, {31'h0, suspended});
        wake_pin <= 1'b0;
        $display("power test done");
        @(posedge pclk);
        presetn <= 1'b0;
        idle(2);
        check("reset power", 32'h03E81BA0, power_ctrl);
        check("reset outputs", 32'h1, {29'h0, irq, int_out, suspended});
        @(posedge pclk);
        presetn <= 1'b1;
        rdc("reset width", hmp_pkg::IDX_IRQ_SHAPE, 32'h0000000F);
        rdc("reset pointer", hmp_pkg::IDX_MEM_PTR, 32'h0);
        $display("mid-run reset test done");
        // ce low must hold the answer back, so the request is still pending
        ce <= 1'b0;
        fork
            rdc("stalled read", hmp_pkg::IDX_MEM_PTR, 32'h0);
            begin
                idle(6);
                check("stalled transfer", 32'h2, {30'h0, psel, pready});
                ce <= 1'b1;
            end
        join
        $display("clock enable test done");
        complete_run();
    end
endmodule // hmp_regs_tb_top

// *** verilog/hmp_regs.sv ***
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module hmp_regs #(
    parameter int MEM_AW = 8,
    parameter int UFRAME_CYCLES = hmp_pkg::UFRAME_CYCLES_DEF,
    parameter int WAKE_TICK_CYCLES = hmp_pkg::WAKE_TICK_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [hmp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_event,
    input wire logic wake_pin,
    output logic irq,
    output logic int_out,
    output logic suspended,
    output hmp_pkg::hmp_pwr_t power_ctrl
);
    localparam int DEPTH = 2 ** MEM_AW;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [15:0] mptr;
        logic [15:0] dptr;
        logic [DEPTH-1:0] valid;
        hmp_pkg::hmp_shape_t shape;
        hmp_pkg::hmp_pwr_t pwr;
        logic edge_mode;
        logic [hmp_pkg::IRQ_N-1:0] sts;
        logic [hmp_pkg::IRQ_N-1:0] en;
        logic irq;
        logic int_out;
        logic [15:0] pulse_cnt;
        logic [7:0] gap_cnt;
        logic edge_pend;
        logic [hmp_pkg::TICK_W-1:0] uf_cnt;
        logic [hmp_pkg::TICK_W-1:0] wk_cnt;
        logic [15:0] wake_cnt;
        hmp_pkg::hmp_pstate_t ps;
        logic suspended;
        logic s1;
        logic s2;
        logic s3;
        logic wflt;
    } hmp_state_t;

    localparam hmp_state_t RST_STATE = '{
        mptr: hmp_pkg::RST_PTR,
        dptr: hmp_pkg::RST_PTR,
        shape: hmp_pkg::RST_SHAPE,
        pwr: hmp_pkg::RST_PWR,
        ps: hmp_pkg::PS_SUSPEND,
        suspended: 1'b1,
        default: '0
    };

    function automatic logic [15:0] incr16(input logic [15:0] x);
        incr16 = x + 16'h0001;
    endfunction

    function automatic logic [MEM_AW-1:0] word_of(input logic [15:0] ptr);
        word_of = ptr[MEM_AW-1:0];
    endfunction

    hmp_state_t r;
    hmp_state_t n;
    logic [15:0] mem [DEPTH];

    logic [hmp_pkg::IDX_W-1:0] reg_idx;
    logic acc;
    logic done;
    logic wr_done;
    logic win_mem;
    logic win_dma;
    logic mem_we;
    logic [MEM_AW-1:0] mem_a;
    logic [31:0] rd_word;
    logic mapped;
    logic [hmp_pkg::IRQ_N-1:0] evt_set;
    logic [hmp_pkg::IRQ_N-1:0] clr;
    logic new_evt;
    logic fire;
    logic uf_tick;
    logic wk_tick;
    logic wake_rise;

    assign reg_idx = paddr[hmp_pkg::ADDR_W-1:2];
    assign acc = psel && penable;
    // one wait state: data is fetched in the first access cycle
    assign done = acc && r.pready;
    assign wr_done = done && pwrite;
    assign win_mem = reg_idx == hmp_pkg::IDX_MEM_DATA;
    assign win_dma = reg_idx == hmp_pkg::IDX_DMA_DATA;
    assign mem_we = wr_done && (win_mem || win_dma);
    assign mem_a = win_dma ? word_of(r.dptr) : word_of(r.mptr);
    assign uf_tick = r.uf_cnt == hmp_pkg::TICK_W'(UFRAME_CYCLES - 1);
    assign wk_tick = r.wk_cnt == hmp_pkg::TICK_W'(WAKE_TICK_CYCLES - 1);
    // filtered level moves only once second and third stages agree
    assign wake_rise = (r.s2 == r.s3) && r.s3 && !r.wflt;
    assign evt_set = {wake_rise, host_event};
    assign clr = (wr_done && reg_idx == hmp_pkg::IDX_IRQ_CLEAR) ? pwdata[hmp_pkg::IRQ_N-1:0] : '0;
    assign new_evt = |(evt_set & r.en);
    // no firing while a pulse runs or the gap is open
    assign fire = r.edge_mode && (new_evt || r.edge_pend) && r.pulse_cnt == 16'h0000
        && r.gap_cnt == 8'h00;

    always_comb begin
        rd_word = 32'h0000_0000;
        mapped = 1'b1;
        case (reg_idx)
            hmp_pkg::IDX_MEM_DATA,
            hmp_pkg::IDX_DMA_DATA: begin
                // unwritten words read as the reset value
                rd_word = r.valid[mem_a] ? {16'h0000, mem[mem_a]} : 32'h0000_0000;
            end
            hmp_pkg::IDX_MEM_PTR: rd_word = {16'h0000, r.mptr};
            hmp_pkg::IDX_DMA_PTR: rd_word = 32'h0000_0000;
            hmp_pkg::IDX_IRQ_SHAPE: rd_word = r.shape;
            hmp_pkg::IDX_PWR: rd_word = r.pwr;
            hmp_pkg::IDX_IRQ_STATUS: rd_word = {{(32 - hmp_pkg::IRQ_N){1'b0}}, r.sts};
            hmp_pkg::IDX_IRQ_CLEAR: rd_word = 32'h0000_0000;
            hmp_pkg::IDX_IRQ_ENABLE: rd_word = {{(32 - hmp_pkg::IRQ_N){1'b0}}, r.en};
            hmp_pkg::IDX_IRQ_MODE: rd_word = {31'h0000_0000, r.edge_mode};
            hmp_pkg::IDX_PWR_STATE: rd_word = {30'h0000_0000, r.ps};
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        n = r;
        n.pslverr = 1'b0;
        n.pready = 1'b0;
        if (acc && !r.pready) begin
            n.pready = 1'b1;
            n.prdata = rd_word;
            n.pslverr = !mapped;
        end
        if (wr_done) begin
            case (reg_idx)
                hmp_pkg::IDX_MEM_PTR: n.mptr = pwdata[15:0];
                hmp_pkg::IDX_DMA_PTR: n.dptr = pwdata[15:0];
                hmp_pkg::IDX_IRQ_SHAPE: n.shape = pwdata;
                hmp_pkg::IDX_PWR: n.pwr = pwdata;
                hmp_pkg::IDX_IRQ_ENABLE: n.en = pwdata[hmp_pkg::IRQ_N-1:0];
                hmp_pkg::IDX_IRQ_MODE: n.edge_mode = pwdata[0];
                default: begin
                end
            endcase
        end
        // every completed window access steps its own pointer only
        if (done && win_mem) begin
            n.mptr = incr16(r.mptr);
        end
        if (done && win_dma) begin
            n.dptr = incr16(r.dptr);
        end
        if (mem_we) begin
            n.valid[mem_a] = 1'b1;
        end

        // set beats a clear landing in the same cycle
        n.sts = (r.sts & ~clr) | evt_set;
        n.irq = |(n.sts & n.en);

        n.uf_cnt = uf_tick ? '0 : incr16(r.uf_cnt);
        if (!r.edge_mode) begin
            n.int_out = n.irq;
            n.pulse_cnt = 16'h0000;
            n.gap_cnt = 8'h00;
            n.edge_pend = 1'b0;
        end else if (fire) begin
            n.int_out = 1'b1;
            n.pulse_cnt = r.shape.irq_pulse_cycles;
            n.gap_cnt = r.shape.min_gap;
            n.edge_pend = 1'b0;
        end else begin
            if (new_evt) begin
                n.edge_pend = 1'b1;
            end
            if (r.pulse_cnt != 16'h0000) begin
                n.pulse_cnt = r.pulse_cnt - 16'h0001;
            end
            n.int_out = r.pulse_cnt > 16'h0001;
            if (uf_tick && r.gap_cnt != 8'h00) begin
                n.gap_cnt = r.gap_cnt - 8'h01;
            end
        end

        n.s1 = wake_pin;
        n.s2 = r.s1;
        n.s3 = r.s2;
        if (r.s2 == r.s3) begin
            n.wflt = r.s3;
        end

        n.wk_cnt = '0;
        case (r.ps)
            hmp_pkg::PS_SUSPEND: begin
                if (r.pwr.host_clock_gate) begin
                    n.ps = hmp_pkg::PS_RUN;
                end else if (wake_rise) begin
                    n.ps = hmp_pkg::PS_HOLD;
                    n.wake_cnt = r.pwr.clk_off_count;
                end
            end
            hmp_pkg::PS_HOLD: begin
                // reprogramming for normal operation cancels the fall-back
                if (r.pwr.host_clock_gate) begin
                    n.ps = hmp_pkg::PS_RUN;
                end else if (wake_rise) begin
                    n.wake_cnt = r.pwr.clk_off_count;
                end else begin
                    n.wk_cnt = wk_tick ? '0 : incr16(r.wk_cnt);
                    if (wk_tick) begin
                        if (r.wake_cnt == 16'h0000) begin
                            n.ps = hmp_pkg::PS_SUSPEND;
                        end else begin
                            n.wake_cnt = r.wake_cnt - 16'h0001;
                        end
                    end
                end
            end
            hmp_pkg::PS_RUN: begin
                if (!r.pwr.host_clock_gate) begin
                    n.ps = hmp_pkg::PS_SUSPEND;
                end
            end
            default: n.ps = hmp_pkg::PS_SUSPEND;
        endcase
        n.suspended = n.ps == hmp_pkg::PS_SUSPEND;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= RST_STATE;
        end else if (ce) begin
            r <= n;
        end
    end

    // the array holds no reset; the valid bits hide stale contents
    always_ff @(posedge pclk) begin
        if (ce && mem_we) begin
            mem[mem_a] <= pwdata[15:0];
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign irq = r.irq;
    assign int_out = r.int_out;
    assign suspended = r.suspended;
    assign power_ctrl = r.pwr;

    logic after_rst;
    logic [15:0] hi_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            after_rst <= 1'b1;
            hi_cnt <= 16'h0000;
        end else begin
            after_rst <= 1'b0;
            if (ce) begin
                hi_cnt <= r.int_out ? incr16(hi_cnt) : 16'h0000;
            end
        end
    end

    property p_mptr_load;
        @(posedge pclk) disable iff (!presetn)
        ce && wr_done && reg_idx == hmp_pkg::IDX_MEM_PTR |=> r.mptr == $past(pwdata[15:0]);
    endproperty
    a_mptr_load: assert property (p_mptr_load) else $error("memory pointer not loaded");

    property p_mptr_step;
        @(posedge pclk) disable iff (!presetn)
        ce && done && win_mem |=> r.mptr == incr16($past(r.mptr)) && r.dptr == $past(r.dptr);
    endproperty
    a_mptr_step: assert property (p_mptr_step) else $error("memory pointer did not advance");

    property p_win_read;
        @(posedge pclk) disable iff (!presetn)
        ce && acc && !r.pready && !pwrite && win_mem |=> r.pready && r.prdata[31:16] == 16'h0000;
    endproperty
    a_win_read: assert property (p_win_read) else $error("window read answer malformed");

    property p_dma_step;
        @(posedge pclk) disable iff (!presetn)
        ce && done && win_dma |=> r.dptr == incr16($past(r.dptr)) && r.mptr == $past(r.mptr);
    endproperty
    a_dma_step: assert property (p_dma_step) else $error("dma window moved wrong pointer");

    property p_dptr_load;
        @(posedge pclk) disable iff (!presetn)
        ce && wr_done && reg_idx == hmp_pkg::IDX_DMA_PTR |=> r.dptr == $past(pwdata[15:0]);
    endproperty
    a_dptr_load: assert property (p_dptr_load) else $error("dma pointer not loaded");

    property p_dptr_rd0;
        @(posedge pclk) disable iff (!presetn)
        ce && acc && !r.pready && !pwrite && reg_idx == hmp_pkg::IDX_DMA_PTR |=> r.pready && r.prdata == 32'h0000_0000;
    endproperty
    a_dptr_rd0: assert property (p_dptr_rd0) else $error("dma pointer read not zero");

    property p_gap_load;
        @(posedge pclk) disable iff (!presetn)
        ce && fire |=> r.int_out && r.gap_cnt == $past(r.shape.min_gap);
    endproperty
    a_gap_load: assert property (p_gap_load) else $error("gap not armed on pulse");

    property p_gap_hold;
        @(posedge pclk) disable iff (!presetn)
        r.edge_mode && r.gap_cnt != 8'h00 |=> !$rose(r.int_out);
    endproperty
    a_gap_hold: assert property (p_gap_hold) else $error("pulse inside minimum gap");

    property p_level;
        @(posedge pclk) disable iff (!presetn)
        !r.edge_mode && !$past(r.edge_mode) |-> r.int_out == r.irq && r.gap_cnt == 8'h00;
    endproperty
    a_level: assert property (p_level) else $error("level output not following irq");

    property p_nogap;
        @(posedge pclk) disable iff (!presetn)
        ce && r.edge_mode && r.shape.min_gap == 8'h00 && r.gap_cnt == 8'h00 && r.pulse_cnt == 16'h0000
            && new_evt |=> r.int_out;
    endproperty
    a_nogap: assert property (p_nogap) else $error("event with zero gap did not pulse");

    property p_width;
        @(posedge pclk) disable iff (!presetn)
        r.edge_mode && $past(r.edge_mode) && $fell(r.int_out) |-> hi_cnt == r.shape.irq_pulse_cycles;
    endproperty
    a_width: assert property (p_width) else $error("edge pulse width wrong");

    property p_rst_vals;
        @(posedge pclk) disable iff (!presetn)
        after_rst |-> r.shape == hmp_pkg::RST_SHAPE && r.dptr == hmp_pkg::RST_PTR;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("shaping reset value wrong");

    property p_pwr;
        @(posedge pclk) disable iff (!presetn)
        (after_rst |-> r.pwr == hmp_pkg::RST_PWR) and
        (ce && wr_done && reg_idx == hmp_pkg::IDX_PWR |=> r.pwr == $past(pwdata));
    endproperty
    a_pwr: assert property (p_pwr) else $error("power control register wrong");

    sequence s_wake;
        ce && r.ps == hmp_pkg::PS_SUSPEND && !r.pwr.host_clock_gate && wake_rise;
    endsequence
    sequence s_expire;
        ce && r.ps == hmp_pkg::PS_HOLD && !r.pwr.host_clock_gate && !wake_rise && wk_tick
            && r.wake_cnt == 16'h0000;
    endsequence

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        s_wake |=> r.ps == hmp_pkg::PS_HOLD && !r.suspended && r.wake_cnt == $past(r.pwr.clk_off_count);
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not start hold interval");

    property p_expire;
        @(posedge pclk) disable iff (!presetn)
        s_expire |=> r.suspended && r.ps == hmp_pkg::PS_SUSPEND;
    endproperty
    a_expire: assert property (p_expire) else $error("hold interval did not end in suspend");
endmodule // hmp_regs
